// ==== rtl/eil_event_latches.sv ====
// e1 event interrupt words one to three and the counter wrap latch
`default_nettype none
// Overview of operation
// - frame pattern bit error in terminal frame sync sets word1 bit7
// - local checksum error sets word1 bit6
// - wrong far-end block bit sets bit5
// - slot sixteen all ones sets bit4
// - non-substitution bipolar violation sets bit3
// - test pattern channel error sets bit2
// - 512 alternating bits set bit1
// - remote alarm bit sets bit0
// - flag sets only when mask bit one
// - reading a word clears its flags
// - counter rollover sets word2 wrap flags
// - test multiframe rollover sets word2 bit1
// - data link a/b set word3 bits6,5
// - jitter buffer margin sets word3 bit4
// - one-second rising edge sets bit3
// - five-second rising edge sets bit2
// - remote alarm with checksum sets bit1
// - signalling change, optionally debounced, sets bit0
// - sticky latch records wraps, ignores masks
module eil_event_latches import eil_pkg::*; #(
    parameter int ALT_BITS = ALT_PAT_BITS,
    parameter int DEB_CYC = DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    // processor port
    input wire eil_cpu_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    // masks, one per flag, 1 = unmasked
    input wire logic [7:0] mask_line_err,
    input wire logic [7:0] mask_wrap,
    input wire logic [7:0] mask_link_tmr,
    input wire logic signalling_debounce_enable,
    // framer conditions, one clock strobes
    input wire logic terminal_frame_sync,
    input wire logic fas_bit_error,
    input wire logic local_crc_error,
    input wire logic ebit_error,
    input wire logic ts16_all_ones,
    input wire logic bipolar_violation,
    input wire logic hdb3_substitution,
    input wire logic prbs_error,
    input wire logic prbs_channel_selected,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic nfas_valid,
    input wire logic [7:0] nfas_word,
    // counter current values, checked for rollover
    input wire logic [7:0] fas_err_count,
    input wire logic [7:0] crc_err_count,
    input wire logic [7:0] ebit_count,
    input wire logic [7:0] bpv_count,
    input wire logic [7:0] prbs_err_count,
    input wire logic [7:0] prbs_mf_count,
    // neighbouring blocks
    input wire logic data_link_a_irq,
    input wire logic data_link_b_irq,
    input wire logic jitter_near_limit,
    input wire logic one_second_status,
    input wire logic five_second_status,
    input wire logic [3:0] rx_signalling,
    output logic [7:0] line_error_event_flags,
    output logic [7:0] counter_wrap_event_flags,
    output logic [7:0] link_timer_signal_event_flags,
    output logic [7:0] counter_wrap_sticky_latch
);
    localparam int DEB_W = $clog2(DEB_CYC + 1);

    // true when an 8-bit counter steps from ff to 00
    function automatic logic rolled(input logic [7:0] prev, input logic [7:0] cur);
        rolled = (prev == 8'hff) && (cur == 8'h00);
    endfunction : rolled

    logic [7:0] raw_line;
    logic [7:0] raw_wrap;
    logic [7:0] raw_link;
    logic [1:0] tick_rise;
    logic alt_seen;
    logic sig_change;
    logic remote_now;
    logic rd_line;
    logic rd_wrap;
    logic rd_link;
    logic rd_sticky;
    logic [7:0] cnt_fas_ff;
    logic [7:0] cnt_crc_ff;
    logic [7:0] cnt_ebit_ff;
    logic [7:0] cnt_bpv_ff;
    logic [7:0] cnt_prbs_ff;
    logic [7:0] cnt_mf_ff;
    logic [ALT_CNT_W-1:0] alt_run_ff;
    logic last_bit_ff;
    logic alt_seen_ff;
    logic [3:0] sig_last_ff;
    logic [3:0] sig_cand_ff;
    logic [DEB_W-1:0] deb_cnt_ff;
    logic [7:0] rdata_ff;

    // one-second and five-second statuses run off a slower timer
    eil_rise_det #(
        .W(2)
    ) u_ticks (
        .clk(clk),
        .sys_rst(sys_rst),
        .level_in({five_second_status, one_second_status}),
        .rise(tick_rise)
    );

    // read decode; a read is one cycle and clears what it returns
    assign rd_line = cpu_req.rd && (cpu_req.addr == ADDR_LINE_ERR);
    assign rd_wrap = cpu_req.rd && (cpu_req.addr == ADDR_WRAP);
    assign rd_link = cpu_req.rd && (cpu_req.addr == ADDR_LINK_TMR);
    assign rd_sticky = cpu_req.rd && (cpu_req.addr == ADDR_STICKY);

    // previous counter values for rollover detection
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_fas_ff <= 8'h00;
            cnt_crc_ff <= 8'h00;
            cnt_ebit_ff <= 8'h00;
            cnt_bpv_ff <= 8'h00;
            cnt_prbs_ff <= 8'h00;
            cnt_mf_ff <= 8'h00;
        end else begin
            cnt_fas_ff <= fas_err_count;
            cnt_crc_ff <= crc_err_count;
            cnt_ebit_ff <= ebit_count;
            cnt_bpv_ff <= bpv_count;
            cnt_prbs_ff <= prbs_err_count;
            cnt_mf_ff <= prbs_mf_count;
        end
    end

    // alternating pattern run length; a repeated bit restarts the run at one
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alt_run_ff <= '0;
            last_bit_ff <= 1'b0;
            alt_seen_ff <= 1'b0;
        end else if (rx_bit_valid) begin
            last_bit_ff <= rx_bit;
            if (alt_run_ff != '0 && rx_bit == last_bit_ff) begin
                alt_run_ff <= ALT_CNT_W'(1);
                alt_seen_ff <= 1'b0;
            end else if (alt_run_ff < ALT_CNT_W'(ALT_BITS)) begin
                alt_run_ff <= alt_run_ff + ALT_CNT_W'(1);
                // fire once, on the 512th alternating bit
                alt_seen_ff <= (alt_run_ff == ALT_CNT_W'(ALT_BITS - 1));
            end else begin
                alt_seen_ff <= 1'b0;
            end
        end else begin
            alt_seen_ff <= 1'b0;
        end
    end
    assign alt_seen = alt_seen_ff;

    // signalling change; with debounce the new pattern must hold a while
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sig_last_ff <= 4'h0;
            sig_cand_ff <= 4'h0;
            deb_cnt_ff <= '0;
        end else if (!signalling_debounce_enable) begin
            sig_last_ff <= rx_signalling;
            sig_cand_ff <= rx_signalling;
            deb_cnt_ff <= '0;
        end else if (rx_signalling != sig_cand_ff) begin
            // a glitch restarts the hold count rather than reporting
            sig_cand_ff <= rx_signalling;
            deb_cnt_ff <= '0;
        end else if (sig_cand_ff != sig_last_ff) begin
            if (deb_cnt_ff == DEB_W'(DEB_CYC - 1)) begin
                sig_last_ff <= sig_cand_ff;
                deb_cnt_ff <= '0;
            end else begin
                deb_cnt_ff <= deb_cnt_ff + DEB_W'(1);
            end
        end
    end
    assign sig_change = signalling_debounce_enable ?
        ((sig_cand_ff != sig_last_ff) && (rx_signalling == sig_cand_ff)
            && (deb_cnt_ff == DEB_W'(DEB_CYC - 1))) :
        (rx_signalling != sig_last_ff);

    assign remote_now = nfas_valid && nfas_word[3];

    // raw event vectors for word one
    always_comb begin
        raw_line = 8'h00;
        raw_line[B_FRAME_ERR] = fas_bit_error && terminal_frame_sync;
        raw_line[B_CHECKSUM] = local_crc_error;
        raw_line[B_BLOCK_ERR] = ebit_error;
        raw_line[B_TS16_ONES] = ts16_all_ones;
        raw_line[B_VIOLATION] = bipolar_violation && !hdb3_substitution;
        raw_line[B_TEST_ERR] = prbs_error && prbs_channel_selected;
        raw_line[B_ALT_PAT] = alt_seen;
        raw_line[B_REMOTE] = remote_now;
    end

    // rollovers feed word two and the sticky latch alike
    always_comb begin
        raw_wrap = 8'h00;
        raw_wrap[B_FRAME_ERR] = rolled(cnt_fas_ff, fas_err_count);
        raw_wrap[B_CHECKSUM] = rolled(cnt_crc_ff, crc_err_count);
        raw_wrap[B_BLOCK_ERR] = rolled(cnt_ebit_ff, ebit_count);
        raw_wrap[B_VIOLATION] = rolled(cnt_bpv_ff, bpv_count);
        raw_wrap[B_TEST_ERR] = rolled(cnt_prbs_ff, prbs_err_count);
        raw_wrap[B_TEST_MF] = rolled(cnt_mf_ff, prbs_mf_count);
    end

    // word three events
    always_comb begin
        raw_link = 8'h00;
        raw_link[B_LINK_A] = data_link_a_irq;
        raw_link[B_LINK_B] = data_link_b_irq;
        raw_link[B_JITTER] = jitter_near_limit;
        raw_link[B_ONE_SEC] = tick_rise[0];
        raw_link[B_FIVE_SEC] = tick_rise[1];
        raw_link[B_RAI_CRC] = remote_now && local_crc_error;
        raw_link[B_SIG_CHG] = sig_change;
    end

    // masked words; a mask bit of one lets the event through
    eil_flag_reg #(
        .USED(8'hff)
    ) u_line (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(raw_line & mask_line_err),
        .rd_clr(rd_line),
        .flags(line_error_event_flags)
    );

    // unused positions are forced low inside the register
    eil_flag_reg #(
        .USED(WRAP_USED)
    ) u_wrap (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(raw_wrap & mask_wrap),
        .rd_clr(rd_wrap),
        .flags(counter_wrap_event_flags)
    );

    eil_flag_reg #(
        .USED(LINK_USED)
    ) u_link (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(raw_link & mask_link_tmr),
        .rd_clr(rd_link),
        .flags(link_timer_signal_event_flags)
    );

    // sticky latch ignores masks so no wrap is ever missed
    eil_flag_reg #(
        .USED(WRAP_USED)
    ) u_sticky (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_evt(raw_wrap),
        .rd_clr(rd_sticky),
        .flags(counter_wrap_sticky_latch)
    );

    // read data registered; it shows the value before the clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else if (cpu_req.rd) begin
            case (cpu_req.addr)
                ADDR_LINE_ERR: rdata_ff <= line_error_event_flags;
                ADDR_WRAP: rdata_ff <= counter_wrap_event_flags;
                ADDR_LINK_TMR: rdata_ff <= link_timer_signal_event_flags;
                ADDR_STICKY: rdata_ff <= counter_wrap_sticky_latch;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end
    assign cpu_rdata = rdata_ff;

    // flag checks start from the raw conditions, not from the set vectors
    a_mask_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        (!mask_line_err[B_BLOCK_ERR] && !line_error_event_flags[B_BLOCK_ERR])
        |=> !line_error_event_flags[B_BLOCK_ERR])
        else $error("masked event set its flag");
    a_frame_sync: assert property (@(posedge clk) disable iff (sys_rst)
        (fas_bit_error && terminal_frame_sync && mask_line_err[B_FRAME_ERR])
        |=> line_error_event_flags[B_FRAME_ERR])
        else $error("frame pattern error not flagged");
    a_bpv_hdb3: assert property (@(posedge clk) disable iff (sys_rst)
        (bipolar_violation && hdb3_substitution && !line_error_event_flags[B_VIOLATION])
        |=> !line_error_event_flags[B_VIOLATION])
        else $error("substitution counted as violation");
    a_remote_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (remote_now && mask_line_err[B_REMOTE]) |=> line_error_event_flags[B_REMOTE])
        else $error("remote alarm not flagged");

    // rollover checks recompute the wrap from the counter inputs
    a_wrap_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        ($past(bpv_count) == 8'hff && bpv_count == 8'h00)
        |=> counter_wrap_sticky_latch[B_VIOLATION])
        else $error("wrap missing from sticky latch");
    a_frame_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        ($past(fas_err_count) == 8'hff && fas_err_count == 8'h00 && mask_wrap[B_FRAME_ERR])
        |=> counter_wrap_event_flags[B_FRAME_ERR])
        else $error("frame error count wrap not flagged");
    a_wrap_flag: assert property (@(posedge clk) disable iff (sys_rst)
        ($past(prbs_mf_count) == 8'hff && prbs_mf_count == 8'h00 && mask_wrap[B_TEST_MF])
        |=> counter_wrap_event_flags[B_TEST_MF])
        else $error("multiframe wrap not flagged");
    a_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
        !counter_wrap_event_flags[4] && !counter_wrap_event_flags[0]
        && !link_timer_signal_event_flags[7]
        && !counter_wrap_sticky_latch[4] && !counter_wrap_sticky_latch[0])
        else $error("unused bit set");

    // status edges take two synchroniser stages and one edge stage
    a_tick_edge: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(one_second_status) && mask_link_tmr[B_ONE_SEC])
        |-> ##3 link_timer_signal_event_flags[B_ONE_SEC])
        else $error("one second edge not flagged");
    a_five_sec_edge: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(five_second_status) && mask_link_tmr[B_FIVE_SEC])
        |-> ##3 link_timer_signal_event_flags[B_FIVE_SEC])
        else $error("five second edge not flagged");
    a_combined_alarm: assert property (@(posedge clk) disable iff (sys_rst)
        (remote_now && local_crc_error && mask_link_tmr[B_RAI_CRC])
        |=> link_timer_signal_event_flags[B_RAI_CRC])
        else $error("combined alarm not flagged");
    a_link_a_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (data_link_a_irq && mask_link_tmr[B_LINK_A])
        |=> link_timer_signal_event_flags[B_LINK_A])
        else $error("data link a event not flagged");
    a_link_b_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (data_link_b_irq && mask_link_tmr[B_LINK_B])
        |=> link_timer_signal_event_flags[B_LINK_B])
        else $error("data link b event not flagged");
    a_jitter_margin: assert property (@(posedge clk) disable iff (sys_rst)
        (jitter_near_limit && mask_link_tmr[B_JITTER])
        |=> link_timer_signal_event_flags[B_JITTER])
        else $error("jitter margin event not flagged");
    // without debounce any sampled pattern change must flag next cycle
    a_sig_plain: assert property (@(posedge clk) disable iff (sys_rst)
        (!signalling_debounce_enable && !$past(signalling_debounce_enable)
            && !$stable(rx_signalling) && mask_link_tmr[B_SIG_CHG])
        |=> link_timer_signal_event_flags[B_SIG_CHG])
        else $error("signalling change not flagged");
endmodule : eil_event_latches
`default_nettype wire

// ==== rtl/eil_flag_reg.sv ====
// one 8-bit clear-on-read flag register
`default_nettype none
module eil_flag_reg import eil_pkg::*; #(
    parameter logic [7:0] USED = 8'hff
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] set_evt,
    input wire logic rd_clr,
    output logic [7:0] flags
);
    logic [7:0] flags_ff;
    // set wins over the read clear so a coincident event survives
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_ff <= FLAGS_RST;
        end else begin
            flags_ff <= ((rd_clr ? 8'h00 : flags_ff) | set_evt) & USED;
        end
    end
    assign flags = flags_ff;
    // set and clear checked per register instance
    a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        (set_evt[0] && USED[0]) |=> flags_ff[0])
        else $error("event lost on read clear");
    a_read_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_clr && set_evt == 8'h00) |=> flags_ff == 8'h00)
        else $error("read did not clear flags");
endmodule : eil_flag_reg
`default_nettype wire

// ==== rtl/eil_pkg.sv ====
// package: register map, field positions and types for the e1 event latches
`default_nettype none
package eil_pkg;
    // register offsets within page 4
    localparam logic [7:0] ADDR_LINE_ERR = 8'h1c;
    localparam logic [7:0] ADDR_WRAP = 8'h1d;
    localparam logic [7:0] ADDR_LINK_TMR = 8'h1e;
    localparam logic [7:0] ADDR_STICKY = 8'h1f;
    // word one field positions
    localparam int B_FRAME_ERR = 7;
    localparam int B_CHECKSUM = 6;
    localparam int B_BLOCK_ERR = 5;
    localparam int B_TS16_ONES = 4;
    localparam int B_VIOLATION = 3;
    localparam int B_TEST_ERR = 2;
    localparam int B_ALT_PAT = 1;
    localparam int B_REMOTE = 0;
    // word two and latch field positions
    localparam int B_TEST_MF = 1;
    // word three field positions
    localparam int B_LINK_A = 6;
    localparam int B_LINK_B = 5;
    localparam int B_JITTER = 4;
    localparam int B_ONE_SEC = 3;
    localparam int B_FIVE_SEC = 2;
    localparam int B_RAI_CRC = 1;
    localparam int B_SIG_CHG = 0;
    // implemented bit masks; other bits read zero
    localparam logic [7:0] WRAP_USED = 8'hee;
    localparam logic [7:0] LINK_USED = 8'h7f;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // alternating pattern length and signalling debounce length
    localparam int ALT_PAT_BITS = 512;
    localparam int DEBOUNCE_CYCLES = 4;
    localparam int ALT_CNT_W = 10;
    // processor access carried as one struct
    typedef struct packed {
        logic rd;
        logic [7:0] addr;
    } eil_cpu_req_t;
endpackage : eil_pkg
`default_nettype wire

// ==== rtl/eil_rise_det.sv ====
// rising-edge detector for status levels from outside the clock domain
`default_nettype none
module eil_rise_det import eil_pkg::*; #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] last_ff;
    // two-stage synchroniser, then one stage of history
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= level_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end
    assign rise = sync_ff & ~last_ff;
endmodule : eil_rise_det
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the e1 event interrupt latches
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top import eil_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    eil_cpu_req_t cpu_req = '0;
    logic [7:0] cpu_rdata, w1, w2, w3, wl;
    logic [7:0] m1 = 8'hff, m2 = 8'hff, m3 = 8'hff;
    logic deb = 1'b0, tfs = 1'b1, fas = 1'b0, crc = 1'b0, ebit = 1'b0, ts16 = 1'b0;
    logic bpv = 1'b0, hdb3 = 1'b0, prbs = 1'b0, psel = 1'b1, rxv = 1'b0, rxb = 1'b0;
    logic nfv = 1'b0, dla = 1'b0, dlb = 1'b0, jit = 1'b0, s1 = 1'b0, s5 = 1'b0;
    logic [7:0] nfw = 8'h00;
    logic [7:0] cnt [6] = '{default: 8'h00};
    logic [3:0] sig = 4'h0;
    int n_errors = 0;
    int compares = 0;
    int wb [6] = '{7, 6, 5, 3, 2, 1};

    // small counts keep the pattern and debounce runs short
    eil_event_latches #(.ALT_BITS(8), .DEB_CYC(2)) uut (
        .clk(clk), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
        .mask_line_err(m1), .mask_wrap(m2), .mask_link_tmr(m3),
        .signalling_debounce_enable(deb), .terminal_frame_sync(tfs),
        .fas_bit_error(fas), .local_crc_error(crc), .ebit_error(ebit),
        .ts16_all_ones(ts16), .bipolar_violation(bpv), .hdb3_substitution(hdb3),
        .prbs_error(prbs), .prbs_channel_selected(psel), .rx_bit_valid(rxv),
        .rx_bit(rxb), .nfas_valid(nfv), .nfas_word(nfw),
        .fas_err_count(cnt[0]), .crc_err_count(cnt[1]), .ebit_count(cnt[2]),
        .bpv_count(cnt[3]), .prbs_err_count(cnt[4]), .prbs_mf_count(cnt[5]),
        .data_link_a_irq(dla), .data_link_b_irq(dlb), .jitter_near_limit(jit),
        .one_second_status(s1), .five_second_status(s5), .rx_signalling(sig),
        .line_error_event_flags(w1), .counter_wrap_event_flags(w2),
        .link_timer_signal_event_flags(w3), .counter_wrap_sticky_latch(wl)
    );

    // 250 MHz clock
    always #2 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // one read cycle; data checked one edge later, gap keeps reads apart
    task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
        cpu_req = '{rd: 1'b1, addr: a};
        @(negedge clk);
        cpu_req = '{rd: 1'b0, addr: a};
        `CHK($sformatf("read %h", a), exp, cpu_rdata)
        @(negedge clk);
    endtask : read_reg

    // raise or drop one event source, codes 0 and 2..7 word one, 14..16 word three
    task automatic set_ev(input int k, input logic v);
        case (k)
            7: fas = v;
            6: crc = v;
            5: ebit = v;
            4: ts16 = v;
            3: bpv = v;
            2: prbs = v;
            0: begin
                nfv = v;
                nfw = v ? 8'h08 : 8'h00;
            end
            16: dla = v;
            15: dlb = v;
            14: jit = v;
            default: ;
        endcase
    endtask : set_ev

    task automatic pulse(input int k);
        set_ev(k, 1'b1);
        tick(1);
        set_ev(k, 1'b0);
    endtask : pulse

    // alternating bit run starting at value b0
    task automatic alt_run(input int n, input logic b0);
        for (int i = 0; i < n; i++) begin
            rxv = 1'b1;
            rxb = b0 ^ i[0];
            tick(1);
        end
        rxv = 1'b0;
        tick(2);
    endtask : alt_run

    task automatic conclude;
        $display("comparisons %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // watchdog cuts a hung run short
    initial begin
        #40000;
        n_errors++;
        conclude();
    end

    initial begin
        tick(5);
        sys_rst = 1'b0;
        tick(1);
        for (int a = 0; a < 4; a++) read_reg(8'h1c + a[7:0], FLAGS_RST);
        // each unmasked word one event except the alternating pattern bit, then clear on read
        for (int b = 0; b < 8; b++) begin
            if (b == 1) continue;
            pulse(b);
            `CHK("word one flag", 8'h01 << b, w1)
            read_reg(8'h1c, 8'h01 << b);
            `CHK("word one cleared", 8'h00, w1)
        end
        // qualifiers block their events
        tfs = 1'b0;
        hdb3 = 1'b1;
        psel = 1'b0;
        pulse(7);
        pulse(3);
        pulse(2);
        tfs = 1'b1;
        hdb3 = 1'b0;
        psel = 1'b1;
        read_reg(8'h1c, 8'h00);
        // masks gate flags
        m1 = 8'h40;
        m3 = 8'h00;
        for (int b = 0; b < 8; b++) pulse(b);
        pulse(16);
        read_reg(8'h1c, 8'h40);
        read_reg(8'h1e, 8'h00);
        m1 = 8'hff;
        m3 = 8'hff;
        // unmapped read returns zero and clears nothing
        pulse(5);
        read_reg(8'h20, 8'h00);
        `CHK("flag kept", 8'h20, w1)
        read_reg(8'h1c, 8'h20);
        // event in the same cycle as the clearing read survives
        crc = 1'b1;
        cpu_req = '{rd: 1'b1, addr: 8'h1c};
        tick(1);
        crc = 1'b0;
        cpu_req = '{rd: 1'b0, addr: 8'h1c};
        `CHK("coincident read data", 8'h00, cpu_rdata)
        tick(1);
        read_reg(8'h1c, 8'h40);
        // short alternating run then a full one after a repeated bit
        alt_run(7, 1'b0);
        read_reg(8'h1c, 8'h00);
        alt_run(12, 1'b0);
        read_reg(8'h1c, 8'h02);
        // each counter rolling over
        for (int i = 0; i < 6; i++) begin
            cnt[i] = 8'hff;
            tick(1);
            cnt[i] = 8'h00;
            tick(2);
            `CHK("wrap flag", 8'h01 << wb[i], w2)
            read_reg(8'h1d, 8'h01 << wb[i]);
            read_reg(8'h1f, 8'h01 << wb[i]);
        end
        // masked wraps still reach the sticky latch
        m2 = 8'h00;
        for (int i = 0; i < 6; i++) cnt[i] = 8'hff;
        tick(1);
        for (int i = 0; i < 6; i++) cnt[i] = 8'h00;
        tick(2);
        read_reg(8'h1d, 8'h00);
        read_reg(8'h1f, 8'hee);
        read_reg(8'h1f, 8'h00);
        m2 = 8'hff;
        // word three sources
        for (int k = 14; k < 17; k++) begin
            pulse(k);
            read_reg(8'h1e, 8'h01 << (k - 10));
        end
        s1 = 1'b1;
        tick(4);
        read_reg(8'h1e, 8'h08);
        s5 = 1'b1;
        tick(4);
        read_reg(8'h1e, 8'h04);
        tick(4);
        read_reg(8'h1e, 8'h00);
        crc = 1'b1;
        set_ev(0, 1'b1);
        tick(1);
        crc = 1'b0;
        set_ev(0, 1'b0);
        read_reg(8'h1e, 8'h02);
        read_reg(8'h1c, 8'h41);
        // signalling change, plain then debounced
        sig = 4'h5;
        tick(2);
        read_reg(8'h1e, 8'h01);
        deb = 1'b1;
        sig = 4'ha;
        tick(1);
        sig = 4'h5;
        tick(4);
        read_reg(8'h1e, 8'h00);
        sig = 4'h3;
        tick(5);
        read_reg(8'h1e, 8'h01);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
